//--- wks_pkg.sv
// Package for the wake key sequence detector: sizes, widths and state encoding.
// Assumes a single 125 MHz clock domain shared by all users of these constants.
`default_nettype none
package wks_pkg;
  localparam int WKS_MAX_ENTRIES = 6;
  localparam int WKS_KEY_W = 4;
  localparam int WKS_LEN_W = 3;
  localparam int WKS_IDX_W = 3;
  localparam logic [WKS_IDX_W-1:0] WKS_IDX_RESET = 3'h0;
  localparam logic [WKS_KEY_W-1:0] WKS_KEY_RESET = 4'h0;
  typedef enum logic [1:0] {
    WKS_DOZE,
    WKS_ACTIVE
  } wks_mode_t;
endpackage
`default_nettype wire

//--- wks_detector.sv
// Wake key sequence detector: holds the device in the low-power scanning state until a
// configured key sequence is entered, or until a host or input event asks for wake-up.
// Assumes key touch and release strobes are single-cycle and synchronous to clk.
// Assumes the configuration inputs hold steady while a sequence is being entered.
// The host side returns the device to the low-power state with enter_doze.
`default_nettype none
module wks_detector
  import wks_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic seq_enable,
  input wire logic [wks_pkg::WKS_LEN_W-1:0] seq_length,
  input wire logic [wks_pkg::WKS_MAX_ENTRIES*wks_pkg::WKS_KEY_W-1:0] seq_keys,
  input wire logic key_touch,
  input wire logic key_release,
  input wire logic [wks_pkg::WKS_KEY_W-1:0] key_id,
  input wire logic general_purpose_input_event,
  input wire logic i2c_wake_cmd,
  input wire logic enter_doze,
  output logic active_mode,
  output logic wake_pulse,
  output logic [wks_pkg::WKS_IDX_W-1:0] seq_progress
);
  import wks_pkg::*;

  // Touch and release tracking.
  logic held_q;
  logic held_d;
  logic [WKS_KEY_W-1:0] held_key_q;
  logic [WKS_KEY_W-1:0] held_key_d;

  // Power mode and position in the sequence.
  wks_mode_t mode_q;
  wks_mode_t mode_d;
  logic [WKS_IDX_W-1:0] idx_q;
  logic [WKS_IDX_W-1:0] idx_d;
  logic wake_d;

  // Next values of the registered outputs.
  logic active_d;
  logic [WKS_IDX_W-1:0] progress_d;

  // Decoded conditions.
  logic [WKS_KEY_W-1:0] expected;
  logic [WKS_KEY_W-1:0] first_key;
  logic [WKS_LEN_W-1:0] eff_len;
  logic key_valid;
  logic ext_wake;
  logic seq_live;
  logic match_next;
  logic match_first;
  logic last_entry;
  logic single_entry;

  // Lengths above the supported maximum are clamped so that a match can always finish.
  assign eff_len = (seq_length > WKS_LEN_W'(WKS_MAX_ENTRIES)) ? WKS_LEN_W'(WKS_MAX_ENTRIES) : seq_length;

  assign expected = seq_keys[idx_q*WKS_KEY_W +: WKS_KEY_W];

  assign first_key = seq_keys[WKS_KEY_W-1:0];

  assign ext_wake = general_purpose_input_event || i2c_wake_cmd;

  // A zero length means no sequence is configured, so keys are ignored then.
  assign seq_live = seq_enable && (eff_len != '0);

  // Touch then release
  // A touch in the same cycle wins, so a coinciding release validates nothing.
  assign key_valid = held_q && key_release && !key_touch && (key_id == held_key_q);

  assign match_next = (key_id == expected);

  assign match_first = (key_id == first_key);

  assign last_entry = (({1'b0, idx_q} + 4'h1) >= {1'b0, eff_len});

  assign single_entry = (eff_len == 3'h1);

  always_comb begin
    held_d = held_q;
    held_key_d = held_key_q;
    if (key_touch) begin
      held_d = 1'b1;
      held_key_d = key_id;
    end else if (key_release) begin
      // Any release ends the hold, so a release of another key is simply dropped.
      held_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_q <= 1'b0;
      held_key_q <= WKS_KEY_RESET;
    end else begin
      held_q <= held_d;
      held_key_q <= held_key_d;
    end
  end

  always_comb begin
    mode_d = mode_q;
    idx_d = idx_q;
    wake_d = 1'b0;
    case (mode_q)
      WKS_DOZE: begin
        if (ext_wake) begin
          mode_d = WKS_ACTIVE;
          wake_d = 1'b1;
          idx_d = WKS_IDX_RESET;
        end else if (!seq_live) begin
          idx_d = WKS_IDX_RESET;
        end else if (key_valid) begin
          if (match_next) begin
            if (last_entry) begin
              mode_d = WKS_ACTIVE;
              wake_d = 1'b1;
              idx_d = WKS_IDX_RESET;
            end else begin
              idx_d = idx_q + 3'h1;
            end
          end else if (match_first) begin
            // Wrong key restarts
            // The wrong key already counts as the first entry of a new attempt.
            if (single_entry) begin
              mode_d = WKS_ACTIVE;
              wake_d = 1'b1;
              idx_d = WKS_IDX_RESET;
            end else begin
              idx_d = 3'h1;
            end
          end else begin
            idx_d = WKS_IDX_RESET;
          end
        end
      end
      WKS_ACTIVE: begin
        idx_d = WKS_IDX_RESET;
        if (enter_doze) begin
          mode_d = WKS_DOZE;
        end
      end
      default: begin
        mode_d = WKS_DOZE;
        idx_d = WKS_IDX_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= WKS_DOZE;
      idx_q <= WKS_IDX_RESET;
    end else begin
      mode_q <= mode_d;
      idx_q <= idx_d;
    end
  end

  // Outputs are taken from the next-state values so that they change on the same edge
  // that samples the causing input, while still coming straight from flip-flops.
  always_comb begin
    active_d = (mode_d == WKS_ACTIVE);
    progress_d = idx_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_mode <= 1'b0;
      wake_pulse <= 1'b0;
      seq_progress <= WKS_IDX_RESET;
    end else begin
      active_mode <= active_d;
      wake_pulse <= wake_d;
      seq_progress <= progress_d;
    end
  end
endmodule
`default_nettype wire

//--- wks_keys.sv
// Key event source for the detector bench; drives on falling clk.
`default_nettype none
module wks_keys (input wire logic clk, output logic key_touch, output logic key_release, output logic [3:0] key_id);
  timeunit 1ns / 1ps;
  initial {key_touch, key_release, key_id} = 6'h0;
  task automatic press(input logic [3:0] id, input int gap = 0, input bit rel = 1);
    @(negedge clk) {key_touch, key_id} = {1'b1, id};
    @(negedge clk) key_touch = 1'b0;
    repeat (gap) @(negedge clk);
    key_release = rel;
    // The stale key number is inverted so nothing can match it by luck.
    @(negedge clk) {key_release, key_id} = {1'b0, ~id};
  endtask
endmodule
`default_nettype wire

//--- wks_detector_props.sv
// Assertions on detector outputs; one clock domain.
`default_nettype none
module wks_detector_props (input wire logic clk, input wire logic rst, input wire logic key_release,
  input wire logic general_purpose_input_event, input wire logic i2c_wake_cmd, input wire logic active_mode,
  input wire logic wake_pulse, input wire logic [wks_pkg::WKS_IDX_W-1:0] seq_progress);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_r; $rose(active_mode) |-> wake_pulse && $past(key_release | general_purpose_input_event | i2c_wake_cmd);
  endproperty
  a_r: assert property (p_r) else $error("bad wake");
  property p_s; seq_progress > $past(seq_progress) |-> $past(key_release) && seq_progress == $past(seq_progress) + 3'h1;
  endproperty
  a_s: assert property (p_s) else $error("bad step");
  property p_d; seq_progress < $past(seq_progress) |-> seq_progress < 3'h2; endproperty
  a_d: assert property (p_d) else $error("bad drop");
  property p_m; seq_progress < 3'h6; endproperty
  a_m: assert property (p_m) else $error("bad count");
  property p_pulse; wake_pulse |-> active_mode && !$past(active_mode); endproperty
  a_pulse: assert property (p_pulse) else $error("bad pulse");
  property p_idle; active_mode |-> seq_progress == 3'h0; endproperty
  a_idle: assert property (p_idle) else $error("bad idle");
endmodule
bind wks_detector wks_detector_props chk_u (.*);
`default_nettype wire

//--- tb_wks_detector.sv
// Bench: a key source and direct wake inputs drive the detector.
`default_nettype none
module tb_wks_detector;
  timeunit 1ns / 1ps;
  logic clk, rst, seq_enable, general_purpose_input_event, i2c_wake_cmd, enter_doze;
  logic key_touch, key_release, active_mode, wake_pulse;
  logic [2:0] seq_length, seq_progress;
  logic [23:0] seq_keys;
  logic [3:0] key_id;
  int mismatches = 0, n_compared = 0;
  always #4 clk = ~clk;
  wks_detector dut_u (.*);
  wks_keys p_u (.*);
  task automatic chk(input logic [3:0] g, e);
    n_compared++;
    if (g !== e) begin mismatches++; $display("CHECK FAILED %0t %h %h", $time, g, e); end
  endtask
  task automatic t_keys;
    p_u.press(4'h2); p_u.press(4'h7, 0, 0); chk(seq_progress, 4'h1);
    p_u.press(4'h7, 3); p_u.press(4'h5); chk(seq_progress, 4'h0);
    p_u.press(4'h2); p_u.press(4'h2); p_u.press(4'h7); chk({active_mode, seq_progress}, 4'h2);
    p_u.press(4'h9); chk({wake_pulse, active_mode}, 4'h3);
  endtask
  task automatic t_off;
    {enter_doze, seq_enable} = 2'h2;
    p_u.press(4'h2); chk({active_mode, seq_progress}, 4'h0);
    {enter_doze, general_purpose_input_event} = 2'h1; @(negedge clk) chk(active_mode, 4'h1);
    {enter_doze, general_purpose_input_event} = 2'h2; @(negedge clk) chk(active_mode, 4'h0);
    {enter_doze, i2c_wake_cmd} = 2'h1; @(negedge clk) chk(active_mode, 4'h1);
  endtask
  // Six entries with an over-long length, then one entry, then no sequence at all.
  task automatic t_len;
    {i2c_wake_cmd, enter_doze, seq_enable, seq_length, seq_keys} = {3'h3, 3'h7, 24'h123456};
    @(negedge clk) enter_doze = 1'b0;
    p_u.press(4'h6); p_u.press(4'h5); p_u.press(4'h4); p_u.press(4'h3); p_u.press(4'h2);
    chk({active_mode, seq_progress}, 4'h5);
    p_u.press(4'h1); chk({wake_pulse, active_mode}, 4'h3);
    {enter_doze, seq_length} = 4'h9; @(negedge clk) enter_doze = 1'b0;
    p_u.press(4'h6); chk({wake_pulse, active_mode}, 4'h3);
    {enter_doze, seq_length} = 4'h8; @(negedge clk) enter_doze = 1'b0;
    p_u.press(4'h6); chk({active_mode, seq_progress}, 4'h0);
  endtask
  initial begin
    {clk, rst, seq_enable, general_purpose_input_event, i2c_wake_cmd, enter_doze} = 6'h18;
    seq_length = 3'h3;
    seq_keys = 24'h000972;
    repeat (8) @(negedge clk);
    rst = 0;
    t_keys();
    t_off();
    t_len();
    results();
  end
  initial begin
    #5000 mismatches++;
    results();
  end
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
endmodule
`default_nettype wire
